// >>> hdl/jlm_mapper.sv
// Transport-layer framer and lane mapper for two 8-lane serial links.
// Assumes an AHB-Lite master, a sample source presenting one whole frame
// per handshake, and a link layer taking one octet per lane per cycle.
// How it works
// RULE1: one mode register alone sets the whole link configuration; the code takes K from km1_r except in modes 30 and 64, and identifiers from did_r.
// RULE2: software writes only listed mode values; others are refused.
// RULE3: multiframe length comes from a field, checked against mode limits.
// RULE4: sixteen lanes as two links of eight; every mode uses both links.
// RULE5: lowest lanes of each link run, the rest are powered down.
// RULE6: lane identifier equals lane index within its own link.
// RULE7: link A reports the device identifier, link B that plus one.
// RULE8: without decimation each sample is packed as 12-bit offset binary.
// RULE9: with decimation each component is 15 data bits plus overrange bit.
// RULE10: every tail bit is zero.
// RULE11: samples go out most significant bit first.
// RULE12: single-channel decimation carries two threshold flags per sample.
// RULE13: dual-channel decimation gives each channel its own flag pair.
// RULE14: dual-channel I/Q pairs of each down-converter travel separately.
// RULE15: 8-lane bypass: A lane k samples 2k+8j, B lane k 2k+1+8j.
// RULE16: mode 30 reuses the 8-lane bypass mapping unchanged.
// RULE17: 64b/66b modes fix multiframe length at 8*32*E/F.
// RULE18: octets leave in ascending order, high nibble first.
`timescale 1ns/1ps
`default_nettype none
`include "jlm_params.svh"
module jlm_mapper import jlm_pkg::*; (
    input wire logic hclk, // Bus and data clock
    input wire logic hresetn, // Asynchronous reset
    input wire logic hsel, // Slave select
    input wire logic [31:0] haddr, // Byte address
    input wire logic [1:0] htrans, // Transfer type
    input wire logic hwrite, // Write when high
    input wire logic [2:0] hsize, // Transfer size
    input wire logic [31:0] hwdata, // Write data
    input wire logic hready, // Bus ready
    output logic [31:0] hrdata, // Read data
    output logic hreadyout, // Slave ready
    output logic hresp, // Always OKAY
    input wire logic frame_valid, // Frame of samples offered
    input wire logic [479:0] frame_samples, // 40 samples of 12 bits
    input wire logic [119:0] ddc_comps, // 8 components of 15 bits
    output logic frame_ready, // Frame taken at this edge
    output logic [127:0] lane_octet, // Octet per lane, lane 0 low
    output logic lane_valid, // Octets valid
    output logic frame_start, // Octet 0 of a frame
    output logic mframe_start, // First frame of a multiframe
    output logic [15:0] lane_en, // Lane powered up
    output logic [47:0] lane_id, // 3-bit identifier per lane
    output logic [7:0] did_a, // Link A device identifier
    output logic [7:0] did_b, // Link B device identifier
    output logic irq // Level interrupt
);
    logic [6:0] mode_r;
    logic [7:0] km1_r, did_r, thr0_r, thr1_r;
    logic [3:0] stat_r, mask_r, ev_c;
    logic pend_r, wr_r;
    logic [7:0] addr_r;
    jlm_state_t st_r;
    logic [2:0] oct_r;
    logic [8:0] fcnt_r, keff_c;
    jlm_frame_t frame_r, pack_c;
    logic load_c, bypass_c, wmode_c, wkm1_c, rstat_c;
    logic [15:0] lanes_c;

    // ----------------------------------------
    // Mode and threshold helpers
    // ----------------------------------------
    function automatic logic mode_ok(input logic [6:0] m);
        mode_ok = (m == `JLM_MODE_BYP) || (m == `JLM_MODE_BYP_ALT)
            || (m == `JLM_MODE_D16_DUAL) || (m == `JLM_MODE_D16_SGL)
            || (m == `JLM_MODE_D16_SGL_66);
    endfunction : mode_ok

    function automatic logic k_ok(input logic [6:0] m, input logic [8:0] k);
        logic [8:0] mn, sm;
        mn = `JLM_K_BYP_MIN;
        sm = `JLM_K_BYP_STEPM;
        if (m == `JLM_MODE_D16_DUAL) begin
            mn = `JLM_K_D16D_MIN;
            sm = `JLM_K_D16D_STEPM;
        end else if (m == `JLM_MODE_D16_SGL) begin
            mn = `JLM_K_D16S_MIN;
            sm = `JLM_K_D16S_STEPM;
        end
        k_ok = (k >= mn) && (k <= `JLM_K_MAX) && (((k - mn) & sm) == 9'h000);
    endfunction : k_ok

    function automatic logic ovr(input logic [14:0] i, input logic [14:0] q,
                                 input logic [7:0] t);
        logic [14:0] ai, aq;
        ai = i[14] ? 15'(~i + 15'h0001) : i;
        aq = q[14] ? 15'(~q + 15'h0001) : q;
        ovr = (ai[14:7] > t) || (aq[14:7] > t);
    endfunction : ovr

    always_comb begin
        bypass_c = (mode_r == `JLM_MODE_BYP) || (mode_r == `JLM_MODE_BYP_ALT); // RULE16
        lanes_c = bypass_c ? {`JLM_LANES_BYP, `JLM_LANES_BYP}
                           : {`JLM_LANES_D16, `JLM_LANES_D16}; // RULE4 RULE5
        if (mode_r == `JLM_MODE_BYP_ALT)
            keff_c = `JLM_KF_BYP_ALT; // RULE17
        else if (mode_r == `JLM_MODE_D16_SGL_66)
            keff_c = `JLM_KF_D16S_66; // RULE17
        else
            keff_c = {1'b0, km1_r} + 9'd1; // RULE3
    end

    // ----------------------------------------
    // AHB-Lite slave
    // ----------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pend_r <= 1'b0;
            wr_r <= 1'b0;
            addr_r <= 8'h00;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else if (hsel && htrans[1] && hready && !pend_r) begin
            pend_r <= 1'b1;
            wr_r <= hwrite;
            addr_r <= haddr[7:0];
            hreadyout <= 1'b0;
        end else begin
            pend_r <= 1'b0;
            hreadyout <= 1'b1;
        end
    end

    always_comb begin
        wmode_c = pend_r && wr_r && (addr_r == `JLM_OFS_MODE);
        wkm1_c = pend_r && wr_r && (addr_r == `JLM_OFS_KM1);
        rstat_c = pend_r && !wr_r && (addr_r == `JLM_OFS_STAT);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (pend_r && !wr_r) begin
            unique case (addr_r)
                `JLM_OFS_MODE: hrdata <= {25'h0, mode_r};
                `JLM_OFS_KM1: hrdata <= {24'h0, km1_r};
                `JLM_OFS_DID: hrdata <= {24'h0, did_r};
                `JLM_OFS_THR0: hrdata <= {24'h0, thr0_r};
                `JLM_OFS_THR1: hrdata <= {24'h0, thr1_r};
                `JLM_OFS_STAT: hrdata <= {28'h0, stat_r};
                `JLM_OFS_MASK: hrdata <= {28'h0, mask_r};
                `JLM_OFS_LANES: hrdata <= {7'h0, fcnt_r, lanes_c};
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_r <= `JLM_RST_MODE;
            km1_r <= `JLM_RST_KM1;
            did_r <= `JLM_RST_DID;
            thr0_r <= `JLM_RST_THR;
            thr1_r <= `JLM_RST_THR;
            mask_r <= `JLM_RST_MASK;
        end else if (pend_r && wr_r) begin
            if (wmode_c && mode_ok(hwdata[6:0]))
                mode_r <= hwdata[6:0]; // RULE1 RULE2
            if (wkm1_c && k_ok(mode_r, {1'b0, hwdata[7:0]} + 9'd1))
                km1_r <= hwdata[7:0]; // RULE3
            if (addr_r == `JLM_OFS_DID)
                did_r <= hwdata[7:0];
            if (addr_r == `JLM_OFS_THR0)
                thr0_r <= hwdata[7:0];
            if (addr_r == `JLM_OFS_THR1)
                thr1_r <= hwdata[7:0];
            if (addr_r == `JLM_OFS_MASK)
                mask_r <= hwdata[3:0];
        end
    end

    // ----------------------------------------
    // Interrupt status, cleared by read; a new event wins over the clear
    // ----------------------------------------
    always_comb begin
        ev_c = 4'h0;
        ev_c[`JLM_ST_MF] = (st_r == JLM_RUN) && (oct_r == 3'd0) && (fcnt_r == 9'd0);
        ev_c[`JLM_ST_BADMODE] = wmode_c && !mode_ok(hwdata[6:0]); // RULE2
        ev_c[`JLM_ST_BADK] = wkm1_c && !k_ok(mode_r, {1'b0, hwdata[7:0]} + 9'd1);
        ev_c[`JLM_ST_UNDER] = (st_r == JLM_RUN) && (oct_r == `JLM_OCT_LAST) && !load_c;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stat_r <= 4'h0;
            irq <= 1'b0;
        end else begin
            stat_r <= (rstat_c ? 4'h0 : stat_r) | ev_c;
            irq <= |(stat_r & mask_r);
        end
    end

    // ----------------------------------------
    // Link identity and lane power
    // ----------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            did_a <= 8'h00;
            did_b <= 8'h00;
            lane_en <= 16'h0000;
            lane_id <= 48'h0000_0000_0000;
        end else begin
            did_a <= did_r; // RULE7
            did_b <= 8'(did_r + 8'h01); // RULE7
            lane_en <= lanes_c; // RULE5
            for (int l = 0; l < 16; l++)
                lane_id[3*l +: 3] <= 3'(l % 8); // RULE6
        end
    end

    // ----------------------------------------
    // Frame packing
    // ----------------------------------------
    always_comb begin
        logic [3:0] f0, f1;
        logic [14:0] ci, cq;
        f0 = 4'h0;
        f1 = 4'h0;
        ci = 15'h0000;
        cq = 15'h0000;
        pack_c = '0; // RULE10
        if (bypass_c) begin
            for (int k = 0; k < 4; k++) begin
                for (int j = 0; j < 5; j++) begin
                    pack_c[k][63-12*j -: 12] = frame_samples[12*(2*k+8*j) +: 12]; // RULE15
                    pack_c[8+k][63-12*j -: 12] = frame_samples[12*(2*k+1+8*j) +: 12]; // RULE8
                end
            end
        end else begin
            for (int c = 0; c < 4; c++) begin
                ci = ddc_comps[30*c +: 15];
                cq = ddc_comps[30*c+15 +: 15];
                f0[c] = ovr(ci, cq, thr0_r); // RULE12 RULE13
                f1[c] = ovr(ci, cq, thr1_r); // RULE12 RULE13
                pack_c[8*(c/2)][63-32*(c%2) -: 32] = {ci, f0[c], cq, f1[c]}; // RULE9 RULE14
            end
        end
    end

    // ----------------------------------------
    // Octet serializer
    // ----------------------------------------
    assign load_c = frame_valid && frame_ready;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r <= JLM_IDLE;
            oct_r <= 3'd0;
            frame_r <= '0;
            frame_ready <= 1'b1;
        end else if (load_c) begin
            st_r <= JLM_RUN;
            oct_r <= 3'd0;
            frame_r <= pack_c;
            frame_ready <= 1'b0;
        end else if (st_r == JLM_RUN) begin
            oct_r <= 3'(oct_r + 3'd1); // RULE18
            if (oct_r == `JLM_OCT_LAST)
                st_r <= JLM_IDLE;
            frame_ready <= (oct_r == 3'd6) || (oct_r == `JLM_OCT_LAST);
        end else begin
            frame_ready <= 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lane_octet <= 128'h0;
            lane_valid <= 1'b0;
            frame_start <= 1'b0;
            mframe_start <= 1'b0;
        end else begin
            lane_valid <= (st_r == JLM_RUN);
            frame_start <= (st_r == JLM_RUN) && (oct_r == 3'd0);
            mframe_start <= ev_c[`JLM_ST_MF];
            for (int l = 0; l < 16; l++)
                lane_octet[8*l +: 8] <= (st_r == JLM_RUN && lanes_c[l])
                    ? frame_r[l][63-8*oct_r -: 8] : 8'h00; // RULE11 RULE18
        end
    end

    // A new mode or length restarts the multiframe
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            fcnt_r <= 9'd0;
        else if (wmode_c || wkm1_c)
            fcnt_r <= 9'd0;
        else if (st_r == JLM_RUN && oct_r == `JLM_OCT_LAST)
            fcnt_r <= (fcnt_r + 9'd1 >= keff_c) ? 9'd0 : 9'(fcnt_r + 9'd1); // RULE3
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_octets;
        lane_valid [*8];
    endsequence

    sequence s_rd_wait;
        !hreadyout ##1 hreadyout;
    endsequence

    chk_did_offset: assert property ($past(hresetn) |-> did_b == 8'(did_a + 8'h01)) // RULE7
        else $error("link B identifier not link A plus one");
    chk_lane_power: assert property ($past(hresetn) |-> lane_en[0] && lane_en[8]
        && lane_en[7:4] == 4'h0 && lane_en[15:12] == 4'h0) // RULE5
        else $error("lane power pattern wrong");
    chk_bad_mode: assert property (wmode_c && !mode_ok(hwdata[6:0])
        |=> mode_r == $past(mode_r) && stat_r[`JLM_ST_BADMODE]) // RULE2
        else $error("unsupported mode accepted");
    chk_tail_zero: assert property (lane_valid && bypass_c && $past(oct_r) == 3'd7
        |-> lane_octet[3:0] == 4'h0 && lane_octet[67:64] == 4'h0) // RULE10
        else $error("tail bits not zero");
    chk_frame_octets: assert property ($rose(st_r == JLM_RUN) |=> s_octets) // RULE18
        else $error("frame shorter than eight octets");
    chk_mf_count: assert property (fcnt_r < keff_c) // RULE3
        else $error("frame count beyond multiframe length");
    chk_fixed_k: assert property (mode_r == `JLM_MODE_D16_SGL_66 |-> keff_c == 9'd128) // RULE17
        else $error("fixed multiframe length wrong");
    chk_irq_level: assert property (##1 irq == |($past(stat_r) & $past(mask_r)))
        else $error("interrupt does not follow status");
    chk_bus_wait: assert property (hsel && htrans[1] && hready && !pend_r |=> s_rd_wait)
        else $error("data phase not one wait state");
    chk_decim_lanes: assert property (lane_valid && !$past(bypass_c) |-> // RULE5
        lane_octet[127:72] == 56'h0 && lane_octet[63:8] == 56'h0)
        else $error("unused decimating lanes not quiet");
    chk_mf_marker: assert property (mframe_start |-> frame_start) // RULE3
        else $error("multiframe marker off frame start");
    chk_lane_ids: assert property ($past(hresetn) |-> lane_id[2:0] == 3'd0 // RULE6
        && lane_id[23:21] == 3'd7 && lane_id[26:24] == 3'd0 && lane_id[47:45] == 3'd7)
        else $error("lane identifiers wrong");
    chk_under_flag: assert property (st_r == JLM_RUN && oct_r == `JLM_OCT_LAST && !load_c
        |=> stat_r[`JLM_ST_UNDER])
        else $error("underrun not flagged");
endmodule : jlm_mapper
`default_nettype wire

// >>> inc/jlm_params.svh
// Constants of the transport lane mapper: register map, reset values,
// supported modes and per-mode multiframe limits.
// Assumes inclusion by the mapper package and the mapper module.
`ifndef JLM_PARAMS_SVH
`define JLM_PARAMS_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define JLM_OFS_MODE 8'h00
`define JLM_OFS_KM1 8'h04
`define JLM_OFS_DID 8'h08
`define JLM_OFS_THR0 8'h0c
`define JLM_OFS_THR1 8'h10
`define JLM_OFS_STAT 8'h14
`define JLM_OFS_MASK 8'h18
`define JLM_OFS_LANES 8'h1c
// ----------------------------------------
// Reset values
// ----------------------------------------
`define JLM_RST_MODE 7'h00
`define JLM_RST_KM1 8'h1f
`define JLM_RST_DID 8'h00
`define JLM_RST_THR 8'hff
`define JLM_RST_MASK 4'h0
// ----------------------------------------
// Status bit positions
// ----------------------------------------
`define JLM_ST_MF 0
`define JLM_ST_BADMODE 1
`define JLM_ST_BADK 2
`define JLM_ST_UNDER 3
// ----------------------------------------
// Supported mode values
// ----------------------------------------
`define JLM_MODE_BYP 7'd0
`define JLM_MODE_BYP_ALT 7'd30
`define JLM_MODE_D16_DUAL 7'd56
`define JLM_MODE_D16_SGL 7'd61
`define JLM_MODE_D16_SGL_66 7'd64
// ----------------------------------------
// Multiframe limits (frames): min, step mask, max
// ----------------------------------------
`define JLM_K_BYP_MIN 9'd16
`define JLM_K_BYP_STEPM 9'd7
`define JLM_K_D16D_MIN 9'd8
`define JLM_K_D16D_STEPM 9'd3
`define JLM_K_D16S_MIN 9'd16
`define JLM_K_D16S_STEPM 9'd7
`define JLM_K_MAX 9'd256
// Fixed-K modes: K = 8*32*E/F
`define JLM_KF_BYP_ALT ((9'd8 * 9'd32 * 9'd1) / 9'd8)
`define JLM_KF_D16S_66 ((9'd8 * 9'd32 * 9'd1) / 9'd2)
// ----------------------------------------
// Lane enables per link (8 lanes per link) and last octet index
// ----------------------------------------
`define JLM_LANES_BYP 8'h0f
`define JLM_LANES_D16 8'h01
`define JLM_OCT_LAST 3'd7
`endif

// >>> inc/jlm_pkg.sv
// Types of the transport lane mapper.
// Assumes jlm_params.svh is on the include path.
`include "jlm_params.svh"
package jlm_pkg;
    typedef enum logic {JLM_IDLE, JLM_RUN} jlm_state_t;
    typedef logic [15:0][63:0] jlm_frame_t;
endpackage : jlm_pkg

// >>> verification/jlm_link_rx.sv
// Behavioural link receiver: gathers the eight octets of each lane into lane words.
// Assumes octets arrive one per lane per clock while lane_valid is high.
`timescale 1ns/1ps
`default_nettype none
module jlm_link_rx (
    input wire logic hclk, // Data clock
    input wire logic hresetn, // Asynchronous reset
    input wire logic [127:0] lane_octet, // Octet per lane
    input wire logic lane_valid, // Octets valid
    input wire logic frame_start, // Octet 0 marker
    input wire logic mframe_start, // Multiframe marker
    output logic [1023:0] rx_frame, // Lane words, lane 0 low
    output logic rx_done, // One frame assembled
    output logic rx_mf, // Frame began a multiframe
    output logic rx_bad // Framing marker out of place
);
    // ----------------------------------------
    // Octet assembly
    // ----------------------------------------
    logic [2:0] oct_r;
    logic [1023:0] acc_r;
    logic [1023:0] acc_nxt;
    always_comb begin
        for (int l = 0; l < 16; l++) begin
            acc_nxt[64*l+:64] = {acc_r[64*l+:56], lane_octet[8*l+:8]};
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            oct_r <= 3'd0;
            acc_r <= '0;
            rx_frame <= '0;
            rx_done <= 1'b0;
            rx_mf <= 1'b0;
            rx_bad <= 1'b0;
        end else begin
            rx_done <= 1'b0;
            if (lane_valid) begin
                acc_r <= acc_nxt;
                oct_r <= oct_r + 3'd1;
                if (frame_start !== (oct_r == 3'd0)) begin
                    rx_bad <= 1'b1;
                end
                if (oct_r == 3'd0) begin
                    rx_mf <= mframe_start;
                end
                if (oct_r == 3'd7) begin
                    rx_frame <= acc_nxt;
                    rx_done <= 1'b1;
                end
            end
        end
    end
endmodule : jlm_link_rx
`default_nettype wire

// >>> verification/testbench.sv
// Self-checking bench for the transport lane mapper.
// Assumes the design, its package and the link receiver model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "jlm_params.svh"
module testbench import jlm_pkg::*;;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, frame_valid, frame_ready;
    logic lane_valid, frame_start, mframe_start, irq, rx_done, rx_bad, rx_mf;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [479:0] frame_samples;
    logic [119:0] ddc_comps;
    logic [127:0] lane_octet;
    logic [15:0] lane_en;
    logic [47:0] lane_id;
    logic [7:0] did_a, did_b, did, thr0, thr1;
    logic [1023:0] rx_frame;
    logic [1023:0] exp_q[$];
    logic mf_q[$];
    int fail_count, samples_checked;
    logic [6:0] modes [5] = '{`JLM_MODE_BYP, `JLM_MODE_BYP_ALT, `JLM_MODE_D16_DUAL,
        `JLM_MODE_D16_SGL, `JLM_MODE_D16_SGL_66};
    logic [7:0] ofs [6] = '{`JLM_OFS_MODE, `JLM_OFS_KM1, `JLM_OFS_DID, `JLM_OFS_THR0,
        `JLM_OFS_THR1, `JLM_OFS_MASK};
    logic [31:0] rst [6] = '{32'h0, 32'h1f, 32'h0, 32'hff, 32'hff, 32'h0};
    assign hready = hreadyout;
    jlm_mapper i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready, .hrdata, .hreadyout, .hresp, .frame_valid, .frame_samples, .ddc_comps,
        .frame_ready, .lane_octet, .lane_valid, .frame_start, .mframe_start, .lane_en,
        .lane_id, .did_a, .did_b, .irq);
    jlm_link_rx i_rx (.hclk, .hresetn, .lane_octet, .lane_valid, .frame_start,
        .mframe_start, .rx_frame, .rx_done, .rx_mf, .rx_bad);
    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end
    // ----------------------------------------
    // Compare, bus and frame tasks
    // ----------------------------------------
    task automatic check32(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : check32
    task automatic check_frame(input string nm, input logic [1023:0] e, input logic [1023:0] g);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : check_frame
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : ahb
    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e,
        input logic [31:0] m);
        ahb(1'b0, a, 32'h0);
        check32(nm, e & m, rd & m);
        check32("response", 32'h0, {31'h0, hresp});
    endtask : rdchk
    task automatic settle_irq(input logic e);
        repeat (3) @(posedge hclk);
        check32("irq", {31'h0, e}, {31'h0, irq});
    endtask : settle_irq
    function automatic logic [1023:0] exp_frame(input logic dec, input logic [479:0] s,
        input logic [119:0] c);
        logic [1023:0] f;
        logic [31:0] p [4];
        logic [14:0] i, q, mi, mq, mx;
        f = '0;
        for (int n = 0; n < 4; n++) begin
            i = c[30*n+:15];
            q = c[30*n+15+:15];
            mi = i[14] ? -i : i;
            mq = q[14] ? -q : q;
            mx = (mi > mq) ? mi : mq;
            p[n] = {i, mx[14:7] > thr0, q, mx[14:7] > thr1};
        end
        if (dec) begin
            f[63:0] = {p[0], p[1]};
            f[575:512] = {p[2], p[3]};
        end else begin
            for (int k = 0; k < 4; k++) begin
                for (int j = 0; j < 5; j++) begin
                    f[64*k+63-12*j-:12] = s[12*(2*k+8*j)+:12];
                    f[64*(k+8)+63-12*j-:12] = s[12*(2*k+1+8*j)+:12];
                end
            end
        end
        return f;
    endfunction : exp_frame
    task automatic send_frame(input logic dec, input logic mf);
        logic [479:0] s;
        logic [119:0] c;
        for (int n = 0; n < 15; n++) begin
            s[32*n+:32] = $urandom;
        end
        for (int n = 0; n < 4; n++) begin
            c[30*n+:30] = 30'($urandom);
        end
        frame_valid <= 1'b1;
        frame_samples <= s;
        ddc_comps <= c;
        exp_q.push_back(exp_frame(dec, s, c));
        mf_q.push_back(mf);
        do @(posedge hclk); while (frame_ready !== 1'b1);
    endtask : send_frame
    task automatic tally_and_finish;
        $display("Comparisons %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : tally_and_finish
    // ----------------------------------------
    // Frame monitor
    // ----------------------------------------
    always @(posedge hclk) begin
        if (rx_done === 1'b1) begin
            if (exp_q.size() == 0) begin
                fail_count++;
                $display("Error frame count expected none seen one");
            end else begin
                check_frame("lane words", exp_q.pop_front(), rx_frame);
                check32("multiframe start", {31'h0, mf_q.pop_front()}, {31'h0, rx_mf});
            end
        end
    end
    initial begin
        repeat (20000) @(posedge hclk);
        fail_count++;
        tally_and_finish();
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {hresetn, hwrite, frame_valid, htrans, haddr, hwdata} = '0;
        {frame_samples, ddc_comps} = '0;
        hsel = 1'b1;
        hsize = 3'b010;
        void'($urandom(54489));
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int n = 0; n < 6; n++) begin
            rdchk("reset value", ofs[n], rst[n], 32'hffffffff);
        end
        rdchk("lane enable reg", `JLM_OFS_LANES, 32'h0f0f, 32'hffff);
        rdchk("unmapped", 8'h20, 32'h0, 32'hffffffff);
        for (int l = 0; l < 16; l++) begin
            check32("lane id", 32'(l % 8), {29'h0, lane_id[3*l+:3]});
        end
        did = 8'($urandom);
        ahb(1'b1, `JLM_OFS_DID, {24'h0, did});
        repeat (2) @(posedge hclk);
        check32("did a", {24'h0, did}, {24'h0, did_a});
        check32("did b", {24'h0, did + 8'h1}, {24'h0, did_b});
        ahb(1'b1, `JLM_OFS_MODE, 32'h2);
        settle_irq(1'b0);
        rdchk("mode kept", `JLM_OFS_MODE, 32'h0, 32'h7f);
        ahb(1'b1, `JLM_OFS_MASK, 32'h6);
        settle_irq(1'b1);
        rdchk("bad mode flag", `JLM_OFS_STAT, 32'h2, 32'h6);
        settle_irq(1'b0);
        ahb(1'b1, `JLM_OFS_KM1, 32'h10);
        rdchk("k kept", `JLM_OFS_KM1, 32'h1f, 32'hff);
        settle_irq(1'b1);
        rdchk("bad k flag", `JLM_OFS_STAT, 32'h4, 32'h4);
        ahb(1'b1, `JLM_OFS_MASK, 32'h0);
        thr0 = 8'($urandom);
        thr1 = 8'($urandom);
        ahb(1'b1, `JLM_OFS_THR0, {24'h0, thr0});
        ahb(1'b1, `JLM_OFS_THR1, {24'h0, thr1});
        for (int m = 0; m < 5; m++) begin
            ahb(1'b1, `JLM_OFS_MODE, {25'h0, modes[m]});
            rdchk("mode", `JLM_OFS_MODE, {25'h0, modes[m]}, 32'h7f);
            check32("lane enable", (m < 2) ? 32'h0f0f : 32'h0101, {16'h0, lane_en});
            send_frame(m >= 2, 1'b1);
            send_frame(m >= 2, 1'b0);
            frame_valid <= 1'b0;
            repeat (14) @(posedge hclk);
            check32("frames pending", 32'h0, 32'(exp_q.size()));
        end
        rdchk("event flags", `JLM_OFS_STAT, 32'h9, 32'hf);
        check32("framing", 32'h0, {31'h0, rx_bad});
        tally_and_finish();
    end
endmodule : testbench
`default_nettype wire
